/* src/sbr_consts.svh */
// constants for the sdram bank activate/read pair: timing, burst codes, register map
// assumes a single 10 MHz clock shared by controller and memory
`ifndef SBR_CONSTS_SVH
`define SBR_CONSTS_SVH

`define SBR_CLK_NS        100
// least times in ns; plain defaults, set to the grade in use
`define SBR_RCD_NS        20
`define SBR_RC_NS         60
`define SBR_RRD_NS        15
`define SBR_RP_NS         20
// least times round up to whole clocks
`define SBR_RCD_CYC ((`SBR_RCD_NS + `SBR_CLK_NS - 1) / `SBR_CLK_NS)
`define SBR_RC_CYC  ((`SBR_RC_NS  + `SBR_CLK_NS - 1) / `SBR_CLK_NS)
`define SBR_RRD_CYC ((`SBR_RRD_NS + `SBR_CLK_NS - 1) / `SBR_CLK_NS)
`define SBR_RP_CYC  ((`SBR_RP_NS  + `SBR_CLK_NS - 1) / `SBR_CLK_NS)

// burst length codes
`define SBR_BL_1          3'h0
`define SBR_BL_2          3'h1
`define SBR_BL_4          3'h2
`define SBR_BL_8          3'h3
`define SBR_BL_CONT       3'h7
// write lead of the data mask before a write
`define SBR_MASK_LEAD     2'h2

// controller register map, byte addresses
`define SBR_REG_CMD       8'h00
`define SBR_REG_WDATA     8'h04
`define SBR_REG_STATUS    8'h08
`define SBR_REG_RDATA     8'h0c
// command register fields
`define SBR_CMD_OP_LSB    0
`define SBR_CMD_AP_BIT    3
`define SBR_CMD_BANK_LSB  4
`define SBR_CMD_ADDR_LSB  6

`endif

/* src/sbr_pkg.sv */
// types shared by the sdram device model, its controller and their interface
// assumes sbr_consts.svh holds the numbers
package sbr_pkg;
  typedef logic [1:0]  sbr_bank_t;
  typedef logic [12:0] sbr_row_t;
  typedef logic [8:0]  sbr_col_t;
  typedef logic [15:0] sbr_word_t;
  typedef enum logic [2:0] {
    sbr_nop,
    sbr_act,
    sbr_rd,
    sbr_wr,
    sbr_pre,
    sbr_bst
  } sbr_cmd_t;
endpackage

/* src/sbr_if.sv */
// command/address/mask/data link between controller and sdram device
// assumes both ends run on the same clock; dq is resolved here from the enables
`timescale 1ns/10ps
interface sbr_if;
  import sbr_pkg::*;
  sbr_cmd_t  cmd;
  sbr_bank_t bank;
  sbr_row_t  addr;
  logic      auto_pre;
  logic      dqm;
  sbr_word_t ctl_dq_o;
  logic      ctl_dq_oe_n;
  sbr_word_t dev_dq_o;
  logic      dev_dq_oe_n;
  wire  [15:0] dq;

  // an undriven bus reads as zero; the enables tell who owns it
  assign dq = !dev_dq_oe_n ? dev_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : 16'h0000);

  modport dev (
    input  cmd, bank, addr, auto_pre, dqm, dq,
    output dev_dq_o, dev_dq_oe_n
  );
  modport ctl (
    output cmd, bank, addr, auto_pre, dqm, ctl_dq_o, ctl_dq_oe_n,
    input  dq, dev_dq_oe_n
  );
endinterface

/* src/sbr_dev.sv */
// sdram device end: bank/row activation and read bursts with cas latency and dqm
// assumes the controller keeps all spacing times; array storage lives outside
// Behaviour
// RL1: read or write needs an opened row
// RL2: access waits activate_to_access_delay after activate
// RL3: no new row before precharging open row
// RL4: same bank activates spaced by same_bank_activate_period
// RL5: cross-bank activates spaced by cross_bank_activate_delay
// RL6: read with auto precharge closes row after burst
// RL7: first word after read_latency, then one per clock
// RL8: data pins released when burst ends
// RL9: continuous page read wraps to column zero
// RL10: read truncates read seamlessly, read_latency-1 early
// RL11: reads accepted every clock, any bank
// RL12: write follows read after last wanted word
// RL13: mask raised two clocks before truncating write
// RL14: write releases pins if mask was high before
// RL15: mask low at write, zero input latency
// RL16: precharge truncates read, read_latency-1 early
// RL17: no command to bank during row_precharge_time
// RL18: explicit precharge at optimum equals auto precharge
// RL19: burst terminate ends read, read_latency-1 early
// RL20: read_latency two or three clocks
// RL21: fixed burst wraps in aligned block, seq/interleaved
// RL22: per-bank open state and burst record kept
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "sbr_consts.svh"
module sbr_dev (
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  sbr_if.dev                   bus,
  input  wire logic            i_read_latency_3,
  input  wire logic [2:0]      i_burst_len,
  input  wire logic            i_burst_interleave,
  output logic                 o_fetch_valid,
  output sbr_pkg::sbr_bank_t   o_fetch_bank,
  output sbr_pkg::sbr_row_t    o_fetch_row,
  output sbr_pkg::sbr_col_t    o_fetch_col,
  input  wire sbr_pkg::sbr_word_t i_fetch_data,
  output logic                 o_store_valid,
  output sbr_pkg::sbr_bank_t   o_store_bank,
  output sbr_pkg::sbr_row_t    o_store_row,
  output sbr_pkg::sbr_col_t    o_store_col,
  output sbr_pkg::sbr_word_t   o_store_data,
  output logic                 o_cmd_error,
  output logic                 o_write_invalid
);
  import sbr_pkg::*;

  typedef struct packed {
    logic [3:0]      open;
    sbr_row_t [3:0]  row;
    logic            bact;
    sbr_bank_t       bbank;
    sbr_col_t        bstart;
    logic [8:0]      bidx;
    logic            bap;
    logic            ap_close;
    sbr_bank_t       ap_bank;
    logic            s0_v;
    sbr_bank_t       s0_bank;
    sbr_row_t        s0_row;
    sbr_col_t        s0_col;
    logic            s1_v;
    sbr_word_t       s1_data;
    logic            dqm_q;
    sbr_word_t       dq;
    logic            dq_oe_n;
    logic            st_v;
    sbr_bank_t       st_bank;
    sbr_row_t        st_row;
    sbr_col_t        st_col;
    sbr_word_t       st_data;
    logic            err;
    logic            winv;
  } sbr_dev_st_t;

  sbr_dev_st_t q, d;

  // low column bits that wrap inside the burst block
  function automatic logic [2:0] blk_mask(input logic [2:0] code);
    case (code)
      `SBR_BL_1: blk_mask = 3'h0;
      `SBR_BL_2: blk_mask = 3'h1;
      `SBR_BL_4: blk_mask = 3'h3;
      default:   blk_mask = 3'h7;
    endcase
  endfunction

  function automatic sbr_col_t burst_col(input sbr_col_t start, input logic [8:0] idx,
                                         input logic [2:0] code, input logic ilv);
    logic [2:0] m;
    logic [2:0] lo;
    m  = blk_mask(code);
    lo = ilv ? (start[2:0] ^ idx[2:0]) : 3'(start[2:0] + idx[2:0]);
    if (code == `SBR_BL_CONT)
      burst_col = 9'(start + idx); // RL9
    else
      burst_col = (start & ~{6'h00, m}) | {6'h00, lo & m}; // RL21
  endfunction

  logic cont;
  logic last;
  logic src_v;
  sbr_word_t src_data;
  assign cont = (i_burst_len == `SBR_BL_CONT);
  assign last = !cont && (q.bidx[2:0] == blk_mask(i_burst_len)) && (q.bidx[8:3] == 6'h00);

  always_comb begin
    d          = q;
    d.s0_v     = 1'b0;
    d.err      = 1'b0;
    d.winv     = 1'b0;
    d.st_v     = 1'b0;
    d.ap_close = 1'b0;
    d.dqm_q    = bus.dqm;
    if (q.ap_close)
      d.open[q.ap_bank] = 1'b0; // RL6 RL18
    // running burst hands out one column each clock
    if (q.bact) begin
      d.s0_v    = 1'b1; // RL7
      d.s0_bank = q.bbank;
      d.s0_row  = q.row[q.bbank]; // RL22
      d.s0_col  = burst_col(q.bstart, q.bidx, i_burst_len, i_burst_interleave);
      d.bidx    = 9'(q.bidx + 9'h001);
      if (last) begin
        d.bact     = 1'b0; // RL8
        d.ap_close = q.bap; // RL6
        d.ap_bank  = q.bbank;
      end
    end
    // read latency pipe: cl2 takes the fetch directly, cl3 one stage later
    d.s1_v    = q.s0_v;
    d.s1_data = i_fetch_data;
    src_v     = i_read_latency_3 ? q.s1_v : q.s0_v; // RL20
    src_data  = i_read_latency_3 ? q.s1_data : i_fetch_data;
    d.dq      = src_data;
    d.dq_oe_n = !(src_v && !q.dqm_q); // RL8 RL13
    case (bus.cmd)
      sbr_act: begin
        if (q.open[bus.bank])
          d.err = 1'b1; // RL3
        else begin
          d.open[bus.bank] = 1'b1; // RL1
          d.row[bus.bank]  = bus.addr;
        end
      end
      sbr_rd: begin
        if (!q.open[bus.bank])
          d.err = 1'b1; // RL1
        else begin
          // new read replaces the old burst on the same edge, no gap
          d.s0_v    = 1'b1; // RL10 RL11
          d.s0_bank = bus.bank;
          d.s0_row  = q.row[bus.bank];
          d.s0_col  = sbr_col_t'(bus.addr);
          d.bstart  = sbr_col_t'(bus.addr);
          d.bbank   = bus.bank;
          d.bidx    = 9'h001;
          d.bact    = (i_burst_len != `SBR_BL_1);
          d.bap     = bus.auto_pre && !cont; // RL6
          if (i_burst_len == `SBR_BL_1) begin
            d.ap_close = bus.auto_pre;
            d.ap_bank  = bus.bank;
          end
        end
      end
      sbr_wr: begin
        d.bact    = 1'b0;
        d.s0_v    = 1'b0;
        d.s1_v    = 1'b0;
        d.dq_oe_n = 1'b1; // RL14
        if ((q.s0_v || q.s1_v || !q.dq_oe_n) && !q.dqm_q)
          d.winv = 1'b1; // RL14
        else if (!q.open[bus.bank])
          d.err = 1'b1; // RL1
        else if (!bus.dqm) begin
          d.st_v    = 1'b1; // RL15
          d.st_bank = bus.bank;
          d.st_row  = q.row[bus.bank];
          d.st_col  = sbr_col_t'(bus.addr);
          d.st_data = bus.dq;
        end
      end
      sbr_pre: begin
        if (bus.auto_pre)
          d.open = 4'h0;
        else
          d.open[bus.bank] = 1'b0;
        if (q.bact && (bus.auto_pre || bus.bank == q.bbank)) begin
          d.bact = 1'b0; // RL16
          d.s0_v = 1'b0;
        end
        if (q.ap_close && (bus.auto_pre || bus.bank == q.ap_bank))
          d.ap_close = 1'b0;
      end
      sbr_bst: begin
        d.bact = 1'b0; // RL19
        d.s0_v = 1'b0;
      end
      default: ;
    endcase
    // a second auto close could land on a just-precharged bank; harmless
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      q         <= '0;
      q.dq_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.dev_dq_o    = q.dq;
  assign bus.dev_dq_oe_n = q.dq_oe_n;
  assign o_fetch_valid   = q.s0_v;
  assign o_fetch_bank    = q.s0_bank;
  assign o_fetch_row     = q.s0_row;
  assign o_fetch_col     = q.s0_col;
  assign o_store_valid   = q.st_v;
  assign o_store_bank    = q.st_bank;
  assign o_store_row     = q.st_row;
  assign o_store_col     = q.st_col;
  assign o_store_data    = q.st_data;
  assign o_cmd_error     = q.err;
  assign o_write_invalid = q.winv;
endmodule // sbr_dev

/* src/sbr_ctl.sv */
// memory controller end: software posts one command at a time, timing is enforced here
// assumes read truncation timing (read_latency-1 early) is chosen by software
`timescale 1ns/10ps
`include "sbr_consts.svh"
module sbr_ctl (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  sbr_if.ctl               bus,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata
);
  import sbr_pkg::*;

  typedef enum logic [1:0] {ctl_idle, ctl_hold, ctl_mask} sbr_ctl_state_t;

  typedef struct packed {
    sbr_ctl_state_t  state;
    sbr_cmd_t        op;
    logic            ap;
    sbr_bank_t       bank;
    sbr_row_t        addr;
    sbr_word_t       wdata;
    logic [1:0]      mcnt;
    logic [3:0]      open;
    logic [3:0][3:0] acc_wait;
    logic [3:0][3:0] act_wait;
    logic [3:0]      rrd_wait;
    logic            refused;
    logic [7:0]      rcount;
    sbr_word_t       rword;
    sbr_cmd_t        cmd;
    sbr_bank_t       cbank;
    sbr_row_t        caddr;
    logic            cap;
    logic            dqm;
    logic            dq_oe_n;
    logic [31:0]     rdata;
  } sbr_ctl_st_t;

  sbr_ctl_st_t q, d;

  // counters are loaded one short since the check sees them a clock late
  function automatic logic [3:0] ld(input int cyc);
    ld = (cyc > 1) ? 4'(cyc - 1) : 4'h0;
  endfunction

  logic ok;

  always_comb begin
    d         = q;
    d.cmd     = sbr_nop;
    d.dq_oe_n = 1'b1;
    d.dqm     = 1'b0;
    ok        = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (q.acc_wait[b] != 4'h0) d.acc_wait[b] = q.acc_wait[b] - 4'h1;
      if (q.act_wait[b] != 4'h0) d.act_wait[b] = q.act_wait[b] - 4'h1;
    end
    if (q.rrd_wait != 4'h0) d.rrd_wait = q.rrd_wait - 4'h1;
    // capture whatever the device drives
    if (!bus.dev_dq_oe_n) begin
      d.rword  = bus.dq;
      d.rcount = 8'(q.rcount + 8'h01);
    end
    // clear first so that a refusal in the same clock still sticks
    if (i_wr && i_addr == `SBR_REG_STATUS)
      d.refused = 1'b0;
    case (q.state)
      ctl_idle: begin
        if (i_wr && i_addr == `SBR_REG_CMD) begin
          d.op    = sbr_cmd_t'(i_wdata[`SBR_CMD_OP_LSB +: 3]);
          d.ap    = i_wdata[`SBR_CMD_AP_BIT];
          d.bank  = i_wdata[`SBR_CMD_BANK_LSB +: 2];
          d.addr  = i_wdata[`SBR_CMD_ADDR_LSB +: 13];
          d.state = ctl_hold;
        end
      end
      ctl_hold: begin
        case (q.op)
          sbr_act: begin
            if (q.open[q.bank]) begin
              d.refused = 1'b1; // RL3
              d.state   = ctl_idle;
            end else
              ok = (q.act_wait[q.bank] == 4'h0) && (q.rrd_wait == 4'h0); // RL4 RL5 RL17
          end
          sbr_rd, sbr_wr: begin
            if (!q.open[q.bank]) begin
              d.refused = 1'b1; // RL1
              d.state   = ctl_idle;
            end else
              ok = (q.acc_wait[q.bank] == 4'h0); // RL2
          end
          default: ok = 1'b1;
        endcase
        if (ok && q.op == sbr_wr) begin
          // mask the read tail first; the idle clocks also cover bus turnaround
          d.state = ctl_mask; // RL12 RL13
          d.mcnt  = `SBR_MASK_LEAD;
          d.dqm   = 1'b1;
        end else if (ok) begin
          d.cmd   = q.op; // RL10 RL16 RL19
          d.cbank = q.bank;
          d.caddr = q.addr;
          d.cap   = q.ap;
          d.state = ctl_idle;
          case (q.op)
            sbr_act: begin
              d.open[q.bank]     = 1'b1;
              d.acc_wait[q.bank] = ld(`SBR_RCD_CYC); // RL2
              d.act_wait[q.bank] = ld(`SBR_RC_CYC); // RL4
              d.rrd_wait         = ld(`SBR_RRD_CYC); // RL5
            end
            sbr_pre: begin
              for (int b = 0; b < 4; b++) begin
                if (q.ap || q.bank == 2'(b)) begin
                  d.open[b]     = 1'b0;
                  d.act_wait[b] = ld(`SBR_RP_CYC); // RL17
                end
              end
            end
            sbr_rd: if (q.ap) d.open[q.bank] = 1'b0;
            default: ;
          endcase
        end
      end
      ctl_mask: begin
        d.mcnt = q.mcnt - 2'h1;
        d.dqm  = (q.mcnt != 2'h1);
        if (q.mcnt == 2'h1) begin
          d.cmd     = sbr_wr; // RL14 RL15
          d.cbank   = q.bank;
          d.caddr   = q.addr;
          d.cap     = 1'b0;
          d.dq_oe_n = 1'b0;
          d.state   = ctl_idle;
        end
      end
      default: d.state = ctl_idle;
    endcase
    if (i_wr && i_addr == `SBR_REG_WDATA)
      d.wdata = i_wdata[15:0];
    if (i_rd) begin
      case (i_addr)
        `SBR_REG_STATUS: d.rdata = {16'h0000, q.rcount, 2'h0, q.open, q.refused,
                                    (q.state != ctl_idle)};
        `SBR_REG_RDATA:  d.rdata = {16'h0000, q.rword};
        `SBR_REG_WDATA:  d.rdata = {16'h0000, q.wdata};
        default:         d.rdata = 32'h0000_0000;
      endcase
    end else
      d.rdata = 32'h0000_0000;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      q         <= '0;
      q.cmd     <= sbr_nop;
      q.dq_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.cmd         = q.cmd;
  assign bus.bank        = q.cbank;
  assign bus.addr        = q.caddr;
  assign bus.auto_pre    = q.cap;
  assign bus.dqm         = q.dqm;
  assign bus.ctl_dq_o    = q.wdata;
  assign bus.ctl_dq_oe_n = q.dq_oe_n;
  assign o_rdata         = q.rdata;
endmodule // sbr_ctl

/* dv/sbr_chk.sv */
// checker for the sbr link between controller and device
// assumes it sits beside the interface, one clock, legal reads only
`timescale 1ns/10ps
module sbr_chk (
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic              i_read_latency_3,
  input wire logic [2:0]        i_burst_len,
  input wire sbr_pkg::sbr_cmd_t  cmd,
  input wire sbr_pkg::sbr_bank_t bank,
  input wire logic              auto_pre,
  input wire logic              dqm,
  input wire logic              ctl_dq_oe_n,
  input wire logic              dev_dq_oe_n
);
  import sbr_pkg::*;
  // auto precharge closes are not tracked: the row check gets weaker, never wrong
  logic [3:0] open_q;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) open_q <= 4'h0;
    else if (cmd == sbr_act) open_q[bank] <= 1'b1;
    else if (cmd == sbr_pre) open_q <= auto_pre ? 4'h0 : open_q & ~(4'h1 << bank);
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_rd_open_row: assert property (cmd == sbr_rd |-> open_q[bank])
    else $error("read sent to a bank without an open row");
  chk_cl2_first_word: assert property (
    cmd == sbr_rd && !i_read_latency_3 && !dqm |-> ##2 !dev_dq_oe_n)
    else $error("first word late at latency two");
  chk_cl3_first_word: assert property (
    (cmd == sbr_rd && i_read_latency_3) ##1 !dqm |-> ##2 !dev_dq_oe_n)
    else $error("first word late at latency three");
  chk_burst_release: assert property (
    (cmd == sbr_rd && !i_read_latency_3 && i_burst_len == 3'h1) ##1 (cmd == sbr_nop)[*3]
    |=> dev_dq_oe_n)
    else $error("data pins not released after burst");
  chk_mask_lead: assert property (cmd == sbr_wr |-> $past(dqm) && $past(dqm, 2))
    else $error("mask not high two clocks before write");
  chk_wr_release: assert property (cmd == sbr_wr |=> dev_dq_oe_n[*2])
    else $error("device drives after write");
  chk_wr_data_drive: assert property (
    cmd == sbr_wr |-> !dqm && !ctl_dq_oe_n ##1 ctl_dq_oe_n)
    else $error("write data masked or not driven one cycle");
  chk_no_contention: assert property (dev_dq_oe_n || ctl_dq_oe_n)
    else $error("both ends drive the data pins");
endmodule // sbr_chk

/* dv/tb.sv */
// self-checking bench: controller and device joined through sbr_if
// assumes a combinational array built from the fetch address
`timescale 1ns/10ps
`include "sbr_consts.svh"
module tb;
  import sbr_pkg::*;
  localparam sbr_row_t ROW = 13'h1a5;
  logic        i_clk, i_reset_n, i_wr, i_rd, rl3, ilv, sv, cerr, winv;
  logic [2:0]  blen;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rd_q;
  sbr_bank_t   fb, sbk;
  sbr_row_t    fr, srw;
  sbr_col_t    fc, scl;
  logic [23:0] st_at;
  sbr_word_t   sd, stored;
  sbr_word_t   seen[$];
  int          failures, comparisons, errs;
  function automatic sbr_word_t word(sbr_bank_t b, sbr_row_t r, sbr_col_t c);
    return {b, c, r[4:0]};
  endfunction
  sbr_if bus();
  sbr_ctl sbr_ctl_i(.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  sbr_dev sbr_dev_i(.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
    .i_read_latency_3(rl3), .i_burst_len(blen), .i_burst_interleave(ilv),
    .o_fetch_valid(), .o_fetch_bank(fb), .o_fetch_row(fr), .o_fetch_col(fc),
    .i_fetch_data(word(fb, fr, fc)), .o_store_valid(sv), .o_store_bank(sbk),
    .o_store_row(srw), .o_store_col(scl), .o_store_data(sd), .o_cmd_error(cerr),
    .o_write_invalid(winv));
  sbr_chk sbr_chk_i(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_read_latency_3(rl3),
    .i_burst_len(blen), .cmd(bus.cmd), .bank(bus.bank), .auto_pre(bus.auto_pre),
    .dqm(bus.dqm), .ctl_dq_oe_n(bus.ctl_dq_oe_n), .dev_dq_oe_n(bus.dev_dq_oe_n));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // word taken at the edge that ends its cycle on the pins
  always @(posedge i_clk) begin
    if (bus.dev_dq_oe_n === 1'b0) seen.push_back(bus.dq);
    if (sv === 1'b1) begin
      stored = sd;
      st_at = {sbk, srw, scl};
    end
    if (cerr === 1'b1 || winv === 1'b1) errs++;
  end
  task conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wreg(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rreg(logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_q = o_rdata;
  endtask
  // posts one command and polls busy; a stuck busy ends the run
  task post(sbr_cmd_t op, logic ap, sbr_bank_t b, sbr_row_t a);
    int n;
    wreg(`SBR_REG_CMD, 32'({a, b, ap, 3'(op)}));
    n = 0;
    do begin
      rreg(`SBR_REG_STATUS);
      n++;
    end while (rd_q[0] !== 1'b0 && n < 40);
    if (rd_q[0] !== 1'b0) begin
      failures++;
      $display("[ERR] busy expected 0 seen %b", rd_q[0]);
      conclude();
    end
  endtask
  task t_act();
    rreg(`SBR_REG_STATUS);
    chk("status at reset", 0, rd_q);
    rreg(8'h10);
    chk("unmapped read", 0, rd_q);
    post(sbr_act, 1'b0, 2'h1, ROW);
    rreg(`SBR_REG_STATUS);
    chk("bank open", 1, rd_q[3]);
    post(sbr_act, 1'b0, 2'h1, ROW);
    rreg(`SBR_REG_STATUS);
    chk("second act refused", 1, rd_q[1]);
    wreg(`SBR_REG_STATUS, 0);
    $display("test act done");
  endtask
  task t_burst(logic c3, logic [2:0] code, logic il, sbr_col_t st);
    int n;
    int k;
    sbr_col_t c;
    n = 1 << code;
    rl3 <= c3;
    blen <= code;
    ilv <= il;
    seen.delete();
    post(sbr_rd, 1'b0, 2'h1, 13'(st));
    k = 0;
    while (seen.size() < n && k < 40) begin
      @(posedge i_clk);
      k++;
    end
    if (seen.size() < n) begin
      failures++;
      $display("[ERR] burst words expected %0d seen %0d", n, seen.size());
      conclude();
    end
    repeat (6) @(posedge i_clk);
    chk("burst word count", n, seen.size());
    for (int j = 0; j < n; j++) begin
      c = il ? sbr_col_t'(st ^ j) : sbr_col_t'((st & ~(n - 1)) | ((st + j) & (n - 1)));
      chk("burst word", word(2'h1, ROW, c), seen[j]);
    end
    $display("test burst cl3=%0d code=%0d ilv=%0d done", c3, code, il);
  endtask
  // page read from column 510, ended by the given command
  task t_cont(sbr_cmd_t op);
    int n;
    rl3 <= 1'b0;
    blen <= `SBR_BL_CONT;
    seen.delete();
    wreg(`SBR_REG_WDATA, 32'h0000_5a3c);
    rreg(`SBR_REG_WDATA);
    chk("write data reg", 32'h0000_5a3c, rd_q);
    post(sbr_rd, 1'b0, 2'h1, 13'h01fe);
    post(op, 1'b0, 2'h1, 13'h0000);
    repeat (8) @(posedge i_clk);
    n = seen.size();
    repeat (8) @(posedge i_clk);
    chk("burst stopped", n, seen.size());
    chk("words before end", 1, n >= 3);
    for (int j = 0; j < n; j++) chk("page word", word(2'h1, ROW, 9'(510 + j)), seen[j]);
    rreg(`SBR_REG_RDATA);
    chk("last word held", word(2'h1, ROW, 9'(509 + n)), rd_q);
    if (op == sbr_wr) chk("stored word", 16'h5a3c, stored);
    if (op == sbr_wr) chk("stored place", {2'h1, ROW, 9'h000}, st_at);
    rreg(`SBR_REG_STATUS);
    chk("bank open after end", op != sbr_pre, rd_q[3]);
    $display("test page read %s done", op.name());
  endtask
  task t_ap();
    post(sbr_act, 1'b0, 2'h1, ROW);
    rl3 <= 1'b1;
    blen <= `SBR_BL_4;
    seen.delete();
    post(sbr_rd, 1'b1, 2'h1, 13'h0000);
    repeat (10) @(posedge i_clk);
    rreg(`SBR_REG_STATUS);
    chk("auto precharge closes", 0, rd_q[3]);
    post(sbr_rd, 1'b0, 2'h1, 13'h0000);
    rreg(`SBR_REG_STATUS);
    chk("read to idle refused", 1, rd_q[1]);
    chk("no extra words", 4, seen.size());
    post(sbr_act, 1'b0, 2'h2, ROW);
    post(sbr_pre, 1'b1, 2'h0, 13'h0000);
    rreg(`SBR_REG_STATUS);
    chk("precharge all", 0, rd_q[5:2]);
    $display("test auto precharge done");
  endtask
  initial begin
    i_reset_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    rl3 = 1'b0;
    blen = 3'h1;
    ilv = 1'b0;
    failures = 0;
    comparisons = 0;
    errs = 0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_act();
    for (int c = 0; c < 2; c++)
      for (int b = 0; b < 4; b++)
        for (int i = 0; i < 2; i++) t_burst(c[0], 3'(b), i[0], 9'h05b);
    t_cont(sbr_bst);
    t_cont(sbr_wr);
    t_cont(sbr_pre);
    t_ap();
    chk("device error pulses", 0, errs);
    conclude();
  end
endmodule // tb
